// ---- pfpw_host.sv ----
// Operation
// - Pages are 128 bytes; unloaded bytes become FF; host loads only the bytes it is given.
// - Host starts each write with select and strobe low, output gate high.
// - Next byte within 200 us keeps the page load open.
// - Host keeps address bits 17..7 equal across one page load, except that an enable request does not close an open page first.
// - Under protection every load needs the three-byte prefix; host sends it for a load only when no page is open or the page changes, and on every enable.
// - Six-byte sequence returns the device to unprotected mode.
// - Enable AA/5555 55/2AAA A0/5555; disable adds 80,AA,55,20 pattern.
// - Chip erase AA,55,80,AA,55,10 at 5555/2AAA/5555 addresses.
// - Identification entry ends 90, exit ends F0, each followed by 10 us.
// - Three-byte exit sequence returns the device to normal reads.
module pfpw_host
	import pfpw_pkg::*;
#(
	parameter int BYTE_LOAD_TIMEOUT_CYC  = PFPW_BYTE_LOAD_TIMEOUT_CYC,
	parameter int GAP_CYC   = PFPW_LOAD_GAP_CYC,
	parameter int PROG_CYC  = PFPW_PROG_CYC,
	parameter int ERASE_CYC = PFPW_ERASE_CYC,
	parameter int PWRON_CYC = PFPW_PWRON_CYC,
	parameter int PAUSE_CYC = PFPW_PAUSE_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire pfpw_req_t   REQ,
	input  wire logic        REQ_VALID,
	output logic             REQ_READY,
	output pfpw_rsp_t        RSP,
	output logic             RSP_VALID,
	input  wire logic        RSP_READY,
	output logic             BUSY,
	output logic             TIMEOUT,
	output logic [17:0]      ADDRESS_LINES,
	output logic [7:0]       DATA_LINES_O,
	output logic             DATA_LINES_OE,
	input  wire logic [7:0]  DATA_LINES_I,
	output logic             CE_N,
	output logic             OE_N,
	output logic             WE_N
);
	typedef enum {S_PWRON, S_IDLE, S_SEQ, S_WSET, S_WLOW, S_WHOLD, S_RD, S_PUSH, S_GAP, S_POLL, S_POLLRD} pfpw_st_t;

	pfpw_st_t     st_reg, st_next;
	pfpw_req_t    cur_reg, cur_next;
	logic [2:0]   step_reg, step_next;
	logic [2:0]   nsteps_reg, nsteps_next;
	logic [31:0]  cnt_reg, cnt_next;
	logic [31:0]  wait_reg, wait_next;
	logic [17:0]  ad_reg, ad_next;
	logic [7:0]   do_reg, do_next;
	logic         oe_reg, oe_next, ce_reg, ce_next, oen_reg, oen_next, we_reg, we_next;
	logic         tmo_reg, tmo_next, open_reg, open_next;
	logic [7:0]   last_reg, last_next;
	logic [17:0]  page_reg, page_next;
	logic [7:0]   s1_reg, s2_reg, s3_reg, din_reg, din_next;
	logic         bin_valid, bin_ready;
	pfpw_rsp_t    bin_data;
	logic [1:0]   bcnt_reg, bcnt_next;
	pfpw_rsp_t    buf0_reg, buf0_next, buf1_reg, buf1_next;
	logic         rdy_reg, vld_reg, busy_reg;

	// Command table: one entry per byte of a command sequence or load prefix.
	function automatic logic [25:0] seq_entry(input pfpw_op_t op, input logic [2:0] idx);
		logic [7:0] last3;
		last3 = (op == PFPW_OP_ID_ENTER) ? PFPW_D_90 : (op == PFPW_OP_ID_EXIT) ? PFPW_D_F0 :
			(op == PFPW_OP_LOAD) ? PFPW_D_A0 : PFPW_D_80;
		case (idx)
			3'h0, 3'h3: seq_entry = {PFPW_ADDR_5555, PFPW_D_AA};
			3'h1, 3'h4: seq_entry = {PFPW_ADDR_2AAA, PFPW_D_55};
			3'h2: seq_entry = {PFPW_ADDR_5555, last3};
			default: seq_entry = {PFPW_ADDR_5555, (op == PFPW_OP_ERASE) ? PFPW_D_10 : PFPW_D_20};
		endcase
	endfunction : seq_entry

	// Three-stage input synchroniser; data is accepted once stages two and three agree.
	always_ff @(posedge CLK) begin
		s1_reg <= DATA_LINES_I;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	assign bin_ready = (bcnt_reg != 2'h2);
	assign bin_valid = (st_reg == S_PUSH);
	assign bin_data  = '{addr: cur_reg.addr, data: din_reg};

	always_comb begin
		bcnt_next = bcnt_reg;
		buf0_next = buf0_reg;
		buf1_next = buf1_reg;
		if (RSP_VALID && RSP_READY) begin
			buf0_next = buf1_reg;
			bcnt_next = bcnt_next - 2'h1;
		end
		if (bin_valid && bin_ready) begin
			if (bcnt_next == 2'h0) begin
				buf0_next = bin_data;
			end else begin
				buf1_next = bin_data;
			end
			bcnt_next = bcnt_next + 2'h1;
		end
	end

	always_comb begin
		st_next = st_reg; cur_next = cur_reg; step_next = step_reg; nsteps_next = nsteps_reg;
		cnt_next = cnt_reg + 32'h1; wait_next = wait_reg; ad_next = ad_reg; do_next = do_reg;
		oe_next = oe_reg; ce_next = ce_reg; oen_next = oen_reg; we_next = we_reg;
		tmo_next = tmo_reg; open_next = open_reg; last_next = last_reg; page_next = page_reg;
		din_next = din_reg;
		if (open_reg && st_reg == S_IDLE && wait_reg >= 32'(GAP_CYC)) begin
			open_next = 1'b0;
		end
		case (st_reg)
			S_PWRON: begin
				if (cnt_reg >= 32'(PWRON_CYC)) begin
					st_next = S_IDLE;
				end
			end
			S_IDLE: begin
				wait_next = wait_reg + 32'h1;
				if (REQ_VALID) begin
					cur_next = REQ; cnt_next = 32'h0; step_next = 3'h0; tmo_next = 1'b0;
					case (REQ.op)
						PFPW_OP_READ: st_next = S_RD;
						PFPW_OP_COMMIT: begin
							st_next = open_reg ? S_GAP : S_IDLE;
							open_next = 1'b0;
						end
						PFPW_OP_LOAD: begin
							// Prefix only at page start; a new page address closes the old page.
							tmo_next = open_reg && REQ.addr[17:7] != page_reg[17:7];
							nsteps_next = (open_reg && !tmo_next) ? 3'h0 : 3'h3;
							st_next = (open_reg && !tmo_next) ? S_WSET : S_SEQ;
							if (tmo_next) begin
								st_next = S_GAP;
								open_next = 1'b0;
							end
						end
						PFPW_OP_PROT_ON: begin cur_next.op = PFPW_OP_LOAD; nsteps_next = 3'h3; st_next = S_SEQ; end
						PFPW_OP_ID_ENTER, PFPW_OP_ID_EXIT: begin nsteps_next = 3'h2; st_next = S_SEQ; end
						default: begin nsteps_next = 3'h5; st_next = S_SEQ; end
					endcase
				end
			end
			S_SEQ: begin
				// Only a load ends with the caller's byte; command sequences come wholly from the table.
				if (step_reg == nsteps_reg && cur_reg.op == PFPW_OP_LOAD) begin
					st_next = S_WSET;
					ad_next = cur_reg.addr; do_next = cur_reg.data;
				end else begin
					{ad_next, do_next} = seq_entry(cur_reg.op, step_reg);
					st_next = S_WSET;
				end
				oe_next = 1'b1; oen_next = 1'b1; cnt_next = 32'h0;
			end
			S_WSET: begin
				if (step_reg == nsteps_reg && cur_reg.op == PFPW_OP_LOAD) begin
					ad_next = cur_reg.addr; do_next = cur_reg.data; oe_next = 1'b1;
				end
				if (cnt_reg >= 32'(PFPW_SETUP_CYC)) begin
					ce_next = 1'b0; we_next = 1'b0; cnt_next = 32'h0; st_next = S_WLOW;
				end
			end
			S_WLOW: begin
				if (cnt_reg >= 32'(PFPW_WE_LOW_CYC)) begin
					we_next = 1'b1; ce_next = 1'b1; cnt_next = 32'h0; st_next = S_WHOLD;
				end
			end
			S_WHOLD: begin
				if (cnt_reg >= 32'(PFPW_SETUP_CYC)) begin
					oe_next = 1'b0;
					if (step_reg < nsteps_reg) begin
						step_next = step_reg + 3'h1; st_next = S_SEQ;
					end else if (cur_reg.op == PFPW_OP_LOAD) begin
						open_next = 1'b1; wait_next = 32'h0; page_next = cur_reg.addr;
						last_next = cur_reg.data; st_next = S_IDLE;
					end else if (cur_reg.op == PFPW_OP_ID_ENTER || cur_reg.op == PFPW_OP_ID_EXIT) begin
						cnt_next = 32'h0; wait_next = 32'(PAUSE_CYC); st_next = S_POLL;
					end else begin
						cnt_next = 32'h0;
						wait_next = (cur_reg.op == PFPW_OP_ERASE) ? 32'(ERASE_CYC) : 32'(PROG_CYC);
						st_next = S_POLL;
					end
				end
			end
			S_GAP: begin
				if (cnt_reg >= 32'(BYTE_LOAD_TIMEOUT_CYC)) begin
					cnt_next = 32'h0; wait_next = 32'(PROG_CYC); st_next = S_POLLRD;
					ad_next = page_reg;
				end
			end
			S_POLL: begin
				if (cnt_reg >= wait_reg) begin
					st_next = S_IDLE; wait_next = 32'h0;
				end
			end
			S_POLLRD: begin
				ce_next = 1'b0; oen_next = 1'b0;
				if ((cnt_reg[3:0] == 4'hf) && (s3_reg == s2_reg) && (s3_reg[7] == last_reg[7])) begin
					ce_next = 1'b1; oen_next = 1'b1; st_next = S_IDLE; wait_next = 32'h0;
				end else if (cnt_reg >= wait_reg) begin
					ce_next = 1'b1; oen_next = 1'b1; tmo_next = 1'b1; st_next = S_IDLE; wait_next = 32'h0;
				end
				// A load that closed the old page was accepted and still owes its prefix and byte.
				if (ce_next && cur_reg.op == PFPW_OP_LOAD) st_next = S_SEQ;
			end
			S_RD: begin
				ad_next = cur_reg.addr; ce_next = 1'b0; oen_next = 1'b0;
				if (cnt_reg >= 32'(PFPW_READ_CYC) && s3_reg == s2_reg && bin_ready) begin
					din_next = s3_reg; st_next = S_PUSH;
				end
			end
			S_PUSH: begin
				ce_next = 1'b1; oen_next = 1'b1; st_next = S_IDLE;
			end
			default: st_next = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			st_reg <= S_PWRON; cur_reg <= '0; step_reg <= 3'h0; nsteps_reg <= 3'h0;
			cnt_reg <= 32'h0; wait_reg <= 32'h0; ad_reg <= 18'h00000; do_reg <= 8'h00;
			oe_reg <= 1'b0; ce_reg <= 1'b1; oen_reg <= 1'b1; we_reg <= 1'b1;
			tmo_reg <= 1'b0; open_reg <= 1'b0; last_reg <= 8'h00; page_reg <= 18'h00000;
			din_reg <= 8'h00; bcnt_reg <= 2'h0; buf0_reg <= '0; buf1_reg <= '0;
			rdy_reg <= 1'b0; vld_reg <= 1'b0; busy_reg <= 1'b1;
		end else begin
			st_reg <= st_next; cur_reg <= cur_next; step_reg <= step_next; nsteps_reg <= nsteps_next;
			cnt_reg <= cnt_next; wait_reg <= wait_next; ad_reg <= ad_next; do_reg <= do_next;
			oe_reg <= oe_next; ce_reg <= ce_next; oen_reg <= oen_next; we_reg <= we_next;
			tmo_reg <= tmo_next; open_reg <= open_next; last_reg <= last_next; page_reg <= page_next;
			din_reg <= din_next; bcnt_reg <= bcnt_next; buf0_reg <= buf0_next; buf1_reg <= buf1_next;
			rdy_reg <= (st_next == S_IDLE); vld_reg <= (bcnt_next != 2'h0); busy_reg <= (st_next != S_IDLE);
		end
	end

	assign REQ_READY     = rdy_reg;
	assign RSP           = buf0_reg;
	assign RSP_VALID     = vld_reg;
	assign BUSY          = busy_reg;
	assign TIMEOUT       = tmo_reg;
	assign ADDRESS_LINES = ad_reg;
	assign DATA_LINES_O  = do_reg;
	assign DATA_LINES_OE = oe_reg;
	assign CE_N          = ce_reg;
	assign OE_N          = oen_reg;
	assign WE_N          = we_reg;

	property p_strobe_gate;
		@(posedge CLK) disable iff (!RSTN) !WE_N |-> (!CE_N && OE_N && DATA_LINES_OE);
	endproperty
	a_strobe_gate: assert property (p_strobe_gate) else $error("write strobe without select and gate high");
	property p_no_contention;
		@(posedge CLK) disable iff (!RSTN) !OE_N |-> !DATA_LINES_OE;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("host drives data while device may");
	property p_pulse_width;
		@(posedge CLK) disable iff (!RSTN) $fell(WE_N) |-> !WE_N [*2];
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("write strobe pulse too short");
	property p_pwron;
		@(posedge CLK) disable iff (!RSTN) (st_reg == S_PWRON) |-> WE_N;
	endproperty
	a_pwron: assert property (p_pwron) else $error("write during power-on hold");
	property p_page_same;
		@(posedge CLK) disable iff (!RSTN) (open_reg && $fell(WE_N) && step_reg == nsteps_reg && nsteps_reg == 3'h0)
			|-> ADDRESS_LINES[17:7] == page_reg[17:7];
	endproperty
	a_page_same: assert property (p_page_same) else $error("page address changed within a load");
	property p_data_stable;
		@(posedge CLK) disable iff (!RSTN) (!WE_N && $past(!WE_N)) |-> $stable(DATA_LINES_O) && $stable(ADDRESS_LINES);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("bus changed during write strobe");
	property p_buf_bound;
		@(posedge CLK) disable iff (!RSTN) bcnt_reg <= 2'h2;
	endproperty
	a_buf_bound: assert property (p_buf_bound) else $error("response buffer overflow");
	property p_poll_quiet;
		@(posedge CLK) disable iff (!RSTN) (st_reg == S_POLLRD || st_reg == S_GAP) |-> WE_N;
	endproperty
	a_poll_quiet: assert property (p_poll_quiet) else $error("write during internal cycle");
	c_load: cover property (@(posedge CLK) disable iff (!RSTN) st_reg == S_WHOLD && cur_reg.op == PFPW_OP_LOAD);
	c_poll: cover property (@(posedge CLK) disable iff (!RSTN) st_reg == S_POLLRD ##1 st_reg == S_IDLE);
	c_read: cover property (@(posedge CLK) disable iff (!RSTN) RSP_VALID && RSP_READY);
	c_full: cover property (@(posedge CLK) disable iff (!RSTN) bcnt_reg == 2'h2);
endmodule : pfpw_host

// ---- pfpw_pkg.sv ----
package pfpw_pkg;
	localparam int           PFPW_AW          = 18;
	localparam int           PFPW_DW          = 8;
	localparam int           PFPW_PAGE_BYTES  = 128;
	localparam int           PFPW_CLK_MHZ     = 100;
	localparam int           PFPW_CLK_NS      = 10;
	localparam int           PFPW_WE_LOW_NS   = 15;
	localparam int           PFPW_WE_LOW_CYC  = (PFPW_WE_LOW_NS + PFPW_CLK_NS - 1) / PFPW_CLK_NS + 1;
	localparam int           PFPW_SETUP_CYC   = 2;
	localparam int           PFPW_READ_NS     = 120;
	localparam int           PFPW_READ_CYC    = (PFPW_READ_NS + PFPW_CLK_NS - 1) / PFPW_CLK_NS + 1;
	localparam int           PFPW_BYTE_LOAD_TIMEOUT_US     = 200;
	localparam int           PFPW_BYTE_LOAD_TIMEOUT_CYC    = PFPW_BYTE_LOAD_TIMEOUT_US * PFPW_CLK_MHZ;
	localparam int           PFPW_LOAD_GAP_US = 100;
	localparam int           PFPW_LOAD_GAP_CYC = PFPW_LOAD_GAP_US * PFPW_CLK_MHZ;
	localparam int           PFPW_PROG_MS     = 10;
	localparam int           PFPW_PROG_CYC    = PFPW_PROG_MS * 1000 * 1000 / PFPW_CLK_NS;
	localparam int           PFPW_ERASE_MS    = 50;
	localparam int           PFPW_ERASE_CYC   = PFPW_ERASE_MS * 1000 * 1000 / PFPW_CLK_NS;
	localparam int           PFPW_PWRON_MS    = 5;
	localparam int           PFPW_PWRON_CYC   = PFPW_PWRON_MS * 1000 * 1000 / PFPW_CLK_NS;
	localparam int           PFPW_PAUSE_US    = 10;
	localparam int           PFPW_PAUSE_CYC   = PFPW_PAUSE_US * PFPW_CLK_MHZ;
	localparam logic [17:0]  PFPW_ADDR_5555   = 18'h05555;
	localparam logic [17:0]  PFPW_ADDR_2AAA   = 18'h02aaa;
	localparam logic [17:0]  PFPW_ADDR_LOCK_LO = 18'h00002;
	localparam logic [17:0]  PFPW_ADDR_LOCK_HI = 18'h3fff2;
	localparam logic [7:0]   PFPW_D_AA        = 8'haa;
	localparam logic [7:0]   PFPW_D_55        = 8'h55;
	localparam logic [7:0]   PFPW_D_A0        = 8'ha0;
	localparam logic [7:0]   PFPW_D_80        = 8'h80;
	localparam logic [7:0]   PFPW_D_20        = 8'h20;
	localparam logic [7:0]   PFPW_D_10        = 8'h10;
	localparam logic [7:0]   PFPW_D_90        = 8'h90;
	localparam logic [7:0]   PFPW_D_F0        = 8'hf0;
	localparam logic [7:0]   PFPW_D_ERASED    = 8'hff;
	localparam logic [7:0]   PFPW_D_LOCKED    = 8'hff;
	localparam logic [7:0]   PFPW_D_UNLOCKED  = 8'hfe;

	typedef enum logic [2:0] {
		PFPW_OP_READ,
		PFPW_OP_LOAD,
		PFPW_OP_PROT_ON,
		PFPW_OP_PROT_OFF,
		PFPW_OP_ERASE,
		PFPW_OP_ID_ENTER,
		PFPW_OP_ID_EXIT,
		PFPW_OP_COMMIT
	} pfpw_op_t;

	typedef struct packed {
		pfpw_op_t    op;
		logic [17:0] addr;
		logic [7:0]  data;
	} pfpw_req_t;

	typedef struct packed {
		logic [17:0] addr;
		logic [7:0]  data;
	} pfpw_rsp_t;
endpackage : pfpw_pkg

// ---- pfpw_flash_model.sv ----
module pfpw_flash_model
	import pfpw_pkg::*;
#(
	parameter int BYTE_LOAD_TIMEOUT_T  = 40,
	parameter int PROG_T  = 200,
	parameter int PWRON_T = 10
) (
	input  wire logic        clk,
	input  wire logic [17:0] addr,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [7:0]  d_in,
	output logic [7:0]       d_out,
	output logic             d_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [int];
	logic [7:0]  pbuf [int];
	logic [7:0]  hd [0:5];
	logic [14:0] ha [0:5];
	logic [17:0] a_lat, last_a, pg;
	logic [7:0]  last_d;
	logic [7:0]  prev = 8'h00;
	logic        prot = 1'b1, armed = 1'b0, idm = 1'b0, lock_lo = 1'b0, lock_hi = 1'b0;
	logic        tog = 1'b0, wr_prev = 1'b1, rd_prev = 1'b0;
	int          low_cnt = 0, byte_load_timeout = -1, busy = 0, age = 0;
	wire         wr = ce_n | we_n;
	assign d_oe = !ce_n && !oe_n;

	function automatic bit pre(int i);
		return hd[i] == PFPW_D_AA && ha[i] == PFPW_ADDR_5555[14:0]
			&& hd[i+1] == PFPW_D_55 && ha[i+1] == PFPW_ADDR_2AAA[14:0];
	endfunction : pre

	function automatic logic [7:0] rdval(logic [17:0] a);
		if (idm && (a == PFPW_ADDR_LOCK_LO || a == PFPW_ADDR_LOCK_HI))
			return (a[17] ? lock_hi : lock_lo) ? PFPW_D_LOCKED : PFPW_D_UNLOCKED;
		if (busy > 0 && a == last_a)
			return {~last_d[7], tog, last_d[5:0]};
		return mem.exists(a) ? mem[a] : PFPW_D_ERASED;
	endfunction : rdval

	task automatic take(logic [17:0] a, logic [7:0] d);
		bit p3, p6, cmd;
		if (busy > 0) return;
		for (int i = 0; i < 5; i++) begin
			hd[i] = hd[i+1];
			ha[i] = ha[i+1];
		end
		hd[5] = d;
		ha[5] = a[14:0];
		p3 = pre(3) && ha[5] == PFPW_ADDR_5555[14:0];
		p6 = p3 && pre(0) && hd[2] == PFPW_D_80;
		cmd = pre(4) || (d == PFPW_D_AA || d == PFPW_D_80) && ha[5] == PFPW_ADDR_5555[14:0];
		if (p6 && d == PFPW_D_20) prot = 1'b0;
		else if (p6 && d == PFPW_D_10) begin
			if (!lock_lo && !lock_hi && age >= PWRON_T) begin
				mem.delete();
				busy = PROG_T;
			end
		end else if (p3 && d == PFPW_D_A0) begin
			prot = 1'b1;
			armed = 1'b1;
		end else if (p3 && d == PFPW_D_90) idm = 1'b1;
		else if (p3 && d == PFPW_D_F0) idm = 1'b0;
		else if (!cmd && (!prot || armed)) begin
			pbuf[a[6:0]] = d;
			pg = a;
			last_a = a;
			last_d = d;
			byte_load_timeout = BYTE_LOAD_TIMEOUT_T;
		end
	endtask : take

	always @(posedge clk) begin
		age++;
		if (busy > 0) busy--;
		if (wr_prev && !wr) a_lat = addr;
		if (!wr_prev && wr && oe_n && low_cnt >= 2) take(a_lat, d_in);
		low_cnt = wr ? 0 : low_cnt + 1;
		wr_prev = wr;
		if (d_oe && !rd_prev) tog = ~tog;
		rd_prev = d_oe;
		if (byte_load_timeout > 0) byte_load_timeout--;
		else if (byte_load_timeout == 0) begin
			byte_load_timeout = -1;
			armed = 1'b0;
			if (age >= PWRON_T && !(lock_lo && pg[17:13] == 0) && !(lock_hi && &pg[17:13])) begin
				for (int i = 0; i < PFPW_PAGE_BYTES; i++)
					mem[{pg[17:7], 7'(i)}] = pbuf.exists(i) ? pbuf[i] : PFPW_D_ERASED;
				busy = PROG_T;
			end
			pbuf.delete();
		end
	end

	// No pull-ups on the data lines, so a released bus shows the complement of the last value.
	always @(negedge clk) begin
		if (d_oe) begin
			d_out = rdval(addr);
			prev = d_out;
		end else d_out = ~prev;
	end
endmodule : pfpw_flash_model

// ---- tb_top.sv ----
module tb_top
	import pfpw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	pfpw_req_t   req = '0;
	logic        req_valid = 1'b0;
	logic        rsp_ready = 1'b0;
	logic        req_ready, rsp_valid, busy, timeout, dl_oe, ce_n, oe_n, we_n, dev_oe;
	pfpw_rsp_t   rsp;
	logic [17:0] addr;
	logic [7:0]  dl_o, dev_q;
	wire  [7:0]  dl_i = dl_oe ? dl_o : dev_q;
	int          error_cnt = 0;
	int          check_count = 0;

	always #5 clk = ~clk;

	pfpw_host #(.BYTE_LOAD_TIMEOUT_CYC(50), .GAP_CYC(200), .PROG_CYC(500), .ERASE_CYC(500), .PWRON_CYC(20))
	u_pfpw_host (.CLK(clk), .RSTN(rstn), .REQ(req), .REQ_VALID(req_valid), .REQ_READY(req_ready), .RSP(rsp),
		.RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .BUSY(busy), .TIMEOUT(timeout), .ADDRESS_LINES(addr),
		.DATA_LINES_O(dl_o), .DATA_LINES_OE(dl_oe), .DATA_LINES_I(dl_i), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n));

	pfpw_flash_model u_pfpw_flash_model (.clk(clk), .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.d_in(dl_i), .d_out(dev_q), .d_oe(dev_oe));

	task automatic end_sim;
		if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic check(logic [25:0] got, logic [25:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wait_idle;
		int n = 0;
		while (req_ready !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		check(26'(n < 3000), 26'h1);
	endtask : wait_idle

	task automatic send(pfpw_op_t op, logic [17:0] a, logic [7:0] d);
		@(negedge clk);
		req = '{op, a, d};
		req_valid = 1'b1;
		wait_idle();
		@(negedge clk);
		req_valid = 1'b0;
	endtask : send

	task automatic get(logic [17:0] a, logic [7:0] d);
		int n = 0;
		@(negedge clk);
		rsp_ready = 1'b1;
		while (rsp_valid !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		check(rsp, {a, d});
		@(negedge clk);
		rsp_ready = 1'b0;
	endtask : get

	task automatic rd(logic [17:0] a, logic [7:0] d);
		send(PFPW_OP_READ, a, 8'h00);
		get(a, d);
	endtask : rd

	task automatic t_reset;
		int n = 0;
		repeat (8) @(negedge clk);
		check({ce_n, oe_n, we_n, dl_oe, rsp_valid}, 26'h1c);
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check(26'(n >= 19 && n < 200), 26'h1);
	endtask : t_reset

	task automatic t_page;
		send(PFPW_OP_LOAD, 18'h00105, 8'h3c);
		send(PFPW_OP_LOAD, 18'h00102, 8'hc3);
		send(PFPW_OP_LOAD, 18'h0017f, 8'h5a);
		send(PFPW_OP_COMMIT, 18'h0017f, 8'h5a);
		wait_idle();
		check(26'(timeout), 26'h0);
		check(26'(u_pfpw_flash_model.prot), 26'h1);
		send(PFPW_OP_READ, 18'h00105, 8'h00);
		send(PFPW_OP_READ, 18'h00102, 8'h00);
		send(PFPW_OP_READ, 18'h00100, 8'h00);
		// The third read must sit inside the host while both buffer entries wait.
		repeat (40) @(negedge clk);
		check(26'(req_ready), 26'h0);
		get(18'h00105, 8'h3c);
		get(18'h00102, 8'hc3);
		get(18'h00100, PFPW_D_ERASED);
		rd(18'h0017f, 8'h5a);
	endtask : t_page

	task automatic t_erase;
		send(PFPW_OP_ERASE, 18'h00000, 8'h00);
		wait_idle();
		rd(18'h00105, PFPW_D_ERASED);
	endtask : t_erase

	task automatic t_ident;
		send(PFPW_OP_ID_ENTER, 18'h00000, 8'h00);
		wait_idle();
		rd(PFPW_ADDR_LOCK_LO, PFPW_D_UNLOCKED);
		rd(PFPW_ADDR_LOCK_HI, PFPW_D_UNLOCKED);
		send(PFPW_OP_ID_EXIT, 18'h00000, 8'h00);
		wait_idle();
		rd(PFPW_ADDR_LOCK_LO, PFPW_D_ERASED);
	endtask : t_ident

	task automatic t_prot;
		send(PFPW_OP_PROT_OFF, 18'h00000, 8'h00);
		wait_idle();
		check(26'(u_pfpw_flash_model.prot), 26'h0);
		send(PFPW_OP_LOAD, 18'h3fe80, 8'h11);
		send(PFPW_OP_COMMIT, 18'h3fe80, 8'h11);
		wait_idle();
		check(26'(u_pfpw_flash_model.prot), 26'h1);
		rd(18'h3fe80, 8'h11);
		rd(18'h3fe81, PFPW_D_ERASED);
		@(negedge clk);
		rstn = 1'b0;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		wait_idle();
		check(26'(u_pfpw_flash_model.prot), 26'h1);
	endtask : t_prot

	task automatic t_turn;
		send(PFPW_OP_PROT_ON, 18'h00200, 8'h77);
		send(PFPW_OP_LOAD, 18'h00300, 8'h88);
		wait_idle();
		check(26'(timeout), 26'h1);
		send(PFPW_OP_COMMIT, 18'h00300, 8'h88);
		wait_idle();
		check(26'(timeout), 26'h0);
		rd(18'h00200, 8'h77);
		rd(18'h00300, 8'h88);
	endtask : t_turn

	always @(negedge clk) begin
		if (rstn && dl_oe && dev_oe) begin
			error_cnt++;
			$display("BAD %0t data lines driven from both ends", $time);
		end
	end

	initial begin
		t_reset();
		t_page();
		t_erase();
		t_ident();
		t_prot();
		t_turn();
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
endmodule : tb_top
